// ==== verilog/afpc_consts.vh ====
// Constants for the output format and power control block.
// Assumes includers are the Verilog-2005 design file and the SystemVerilog bench.
//
// Functional notes
// - In nap, lanes keep sending valid encoded characters.
// - In nap, payload repeats the last valid sample until nap ends.
// - In sleep, lanes are off; receiver realigns code groups after wake.
// - After power-on, pin picks state: low normal, float nap, high sleep.
// - Calibration always runs first; nap or sleep only entered afterwards.
// - A power state programmed over SPI overrides the pin.
// - Powered up in nap or sleep, SPI stays off until pin shows normal.
// - Format register picks two's complement (default), Gray or offset binary.
// - Offset binary: minus full scale all zeros, plus full scale all ones.
// - Two's complement is offset binary with the top bit inverted.
// - Gray keeps top bit; lower bits XOR binary bit with bit above.
// - Sync pair is link sync by default; register makes it divider reset.
// - Writing one to soft reset reruns power-on reset and calibration; block only recalibrates, format and sync regs keep values.
// - Soft reset bit clears itself when recalibration finishes.
// - Out-of-range input clamps output to the full-scale code.
`ifndef AFPC_CONSTS_VH
`define AFPC_CONSTS_VH
`define AFPC_W 14
`define AFPC_ADDR_SOFT_RESET 8'h00
`define AFPC_ADDR_FORMAT 8'h73
`define AFPC_ADDR_SYNC_FUNC 8'h77
`define AFPC_SOFT_RESET_BIT 0
`define AFPC_PWR_LSB 4
`define AFPC_PWR_MSB 5
`define AFPC_FMT_MSB 1
`define AFPC_SYNC_FUNC_BIT 0
`define AFPC_CHANNELS 2
`define AFPC_FMT_TWOS 2'h0
`define AFPC_FMT_GRAY 2'h1
`define AFPC_FMT_OFFSET 2'h2
`define AFPC_FMT_RESET 2'h0
`define AFPC_PIN_NORMAL 2'h0
`define AFPC_PIN_NAP 2'h1
`define AFPC_PIN_SLEEP 2'h2
`define AFPC_PWR_PIN 2'h0
`define AFPC_PWR_NORMAL 2'h1
`define AFPC_PWR_NAP 2'h2
`define AFPC_PWR_SLEEP 2'h3
`define AFPC_FIFO_DEPTH 8
`define AFPC_FIFO_AW 3
`endif

// ==== verilog/afpc_top.v ====
// Output format, power state and soft reset control, plus sample FIFO.
// Assumes samples, calibration done and the register port are synchronous
// to ref_clk; the register port is a simple write/read strobe interface.
`timescale 1ns/1ns
`include "afpc_consts.vh"

////////////////////////////////////////////////////////////////////////////
module afpc_fifo #(
	parameter WIDTH = 28,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire ref_clk,
	input wire reset,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW-1:0] rd_ptr_reg;
	reg [AW:0] count_reg;
	wire do_wr;
	wire do_rd;
	assign in_ready = (count_reg != DEPTH[AW:0]);
	assign out_valid = (count_reg != {(AW+1){1'b0}});
	assign out_data = mem_reg[rd_ptr_reg];
	assign do_wr = in_valid & in_ready;
	assign do_rd = out_valid & out_ready;
	always @(posedge ref_clk) begin
		if (do_wr)
			mem_reg[wr_ptr_reg] <= in_data;
	end
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			wr_ptr_reg <= {AW{1'b0}};
			rd_ptr_reg <= {AW{1'b0}};
			count_reg <= {(AW+1){1'b0}};
		end else begin
			if (do_wr)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (do_rd)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			if (do_wr & ~do_rd)
				count_reg <= count_reg + 1'b1;
			else if (do_rd & ~do_wr)
				count_reg <= count_reg - 1'b1;
		end
	end
endmodule // afpc_fifo

////////////////////////////////////////////////////////////////////////////
module afpc_top (
	input wire ref_clk,
	input wire reset,
	input wire [1:0] power_state_pin,
	input wire spi_select_low,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata,
	output reg reg_rvalid,
	input wire cal_done,
	output reg cal_start,
	input wire sample_valid,
	input wire [`AFPC_W-1:0] sample_a,
	input wire [`AFPC_W-1:0] sample_b,
	input wire over_a,
	input wire over_b,
	input wire under_a,
	input wire under_b,
	input wire sync_pair_pos,
	input wire sync_pair_neg,
	output reg link_sync_n,
	output reg div_sync_reset,
	output reg lane_enable,
	output reg lane_valid,
	output reg [`AFPC_W-1:0] lane_data_a,
	output reg [`AFPC_W-1:0] lane_data_b,
	input wire lane_ready,
	output reg sample_ready,
	output reg nap_active,
	output reg sleep_active,
	output reg calibrating
);
	localparam ST_CAL = 3'b001;
	localparam ST_RUN = 3'b010;
	localparam ST_START = 3'b100;

	reg [2:0] state_reg;
	reg soft_reset_reg;
	reg [1:0] format_reg;
	reg sync_func_reg;
	reg [1:0] spi_power_reg;
	reg spi_enabled_reg;
	reg [`AFPC_W-1:0] hold_a_reg;
	reg [`AFPC_W-1:0] hold_b_reg;
	reg [1:0] eff_state;
	reg [7:0] rd_image;
	wire [`AFPC_CHANNELS*`AFPC_W-1:0] smp_all;
	wire [`AFPC_CHANNELS-1:0] over_all;
	wire [`AFPC_CHANNELS-1:0] under_all;
	wire [`AFPC_CHANNELS*`AFPC_W-1:0] enc_all;
	wire sample_take;
	wire fifo_in_ready;
	wire fifo_out_valid;
	wire [2*`AFPC_W-1:0] fifo_out_data;
	wire in_nap;
	wire in_sleep;
	wire reg_ok;
	genvar ch;

	////////////////////////////////////////////////////////////////////////////
	// Clamping and output coding
	function [`AFPC_W-1:0] clamp_ob;
		input [`AFPC_W-1:0] s;
		input ov;
		input un;
		begin
			if (ov)
				clamp_ob = {`AFPC_W{1'b1}};
			else if (un)
				clamp_ob = {`AFPC_W{1'b0}};
			else
				clamp_ob = s;
		end
	endfunction

	function [`AFPC_W-1:0] encode;
		input [`AFPC_W-1:0] ob;
		input [1:0] fmt;
		begin
			case (fmt)
			`AFPC_FMT_GRAY: encode = ob ^ (ob >> 1);
			`AFPC_FMT_OFFSET: encode = ob;
			default: encode = {~ob[`AFPC_W-1], ob[`AFPC_W-2:0]};
			endcase
		end
	endfunction

	assign smp_all = {sample_a, sample_b};
	assign over_all = {over_a, over_b};
	assign under_all = {under_a, under_b};
	// Channel 1 carries A, channel 0 carries B
	generate
		for (ch = 0; ch < `AFPC_CHANNELS; ch = ch + 1) begin : g_chan
			assign enc_all[ch*`AFPC_W +: `AFPC_W] = encode(
			    clamp_ob(smp_all[ch*`AFPC_W +: `AFPC_W], over_all[ch],
			    under_all[ch]), format_reg);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Power state
	// Pin decides unless SPI programmed a state
	always @* begin
		eff_state = `AFPC_PWR_NORMAL;
		if (state_reg != ST_RUN)
			eff_state = `AFPC_PWR_NORMAL;
		else if (spi_power_reg != `AFPC_PWR_PIN)
			eff_state = spi_power_reg;
		else if (power_state_pin == `AFPC_PIN_NAP)
			eff_state = `AFPC_PWR_NAP;
		else if (power_state_pin == `AFPC_PIN_SLEEP)
			eff_state = `AFPC_PWR_SLEEP;
	end
	assign in_nap = (eff_state == `AFPC_PWR_NAP);
	assign in_sleep = (eff_state == `AFPC_PWR_SLEEP);
	assign reg_ok = spi_enabled_reg & ~spi_select_low & ~calibrating &
	    (state_reg == ST_RUN);
	assign sample_take = sample_valid & sample_ready & ~in_nap & ~in_sleep;

	////////////////////////////////////////////////////////////////////////////
	// Sample buffering; ready is registered, so it drops after each take
	afpc_fifo #(
		.WIDTH(2*`AFPC_W),
		.DEPTH(`AFPC_FIFO_DEPTH),
		.AW(`AFPC_FIFO_AW)
	) u_fifo (
		.ref_clk(ref_clk),
		.reset(reset),
		.in_valid(sample_take),
		.in_ready(fifo_in_ready),
		.in_data(enc_all),
		.out_valid(fifo_out_valid),
		.out_ready(lane_ready & ~in_sleep & ~in_nap),
		.out_data(fifo_out_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Register read image
	always @* begin
		rd_image = 8'h00;
		case (reg_addr)
		`AFPC_ADDR_SOFT_RESET: begin
			rd_image[`AFPC_SOFT_RESET_BIT] = soft_reset_reg;
			rd_image[`AFPC_PWR_MSB:`AFPC_PWR_LSB] = spi_power_reg;
		end
		`AFPC_ADDR_FORMAT: rd_image[`AFPC_FMT_MSB:0] = format_reg;
		`AFPC_ADDR_SYNC_FUNC: rd_image[`AFPC_SYNC_FUNC_BIT] = sync_func_reg;
		default: rd_image = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Control sequencing and register writes
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_reg <= ST_START;
			soft_reset_reg <= 1'b0;
			format_reg <= `AFPC_FMT_RESET;
			sync_func_reg <= 1'b0;
			spi_power_reg <= `AFPC_PWR_PIN;
			spi_enabled_reg <= 1'b0;
			hold_a_reg <= {`AFPC_W{1'b0}};
			hold_b_reg <= {`AFPC_W{1'b0}};
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
			cal_start <= 1'b0;
			link_sync_n <= 1'b1;
			div_sync_reset <= 1'b0;
			lane_enable <= 1'b0;
			lane_valid <= 1'b0;
			lane_data_a <= {`AFPC_W{1'b0}};
			lane_data_b <= {`AFPC_W{1'b0}};
			sample_ready <= 1'b0;
			nap_active <= 1'b0;
			sleep_active <= 1'b0;
			calibrating <= 1'b1;
		end else begin
			cal_start <= 1'b0;
			reg_rvalid <= 1'b0;
			case (state_reg)
			ST_START: begin
				cal_start <= 1'b1;
				state_reg <= ST_CAL;
			end
			ST_CAL: begin
				if (cal_done) begin
					state_reg <= ST_RUN;
					soft_reset_reg <= 1'b0;
				end
			end
			ST_RUN: begin
				if (spi_power_reg == `AFPC_PWR_PIN &&
				    power_state_pin == `AFPC_PIN_NORMAL)
					spi_enabled_reg <= 1'b1;
				if (reg_ok & reg_wr) begin
					case (reg_addr)
					`AFPC_ADDR_SOFT_RESET: begin
						if (reg_wdata[`AFPC_SOFT_RESET_BIT]) begin
							soft_reset_reg <= 1'b1;
							state_reg <= ST_START;
						end
					end
					`AFPC_ADDR_FORMAT:
						format_reg <= reg_wdata[`AFPC_FMT_MSB:0];
					`AFPC_ADDR_SYNC_FUNC:
						sync_func_reg <= reg_wdata[`AFPC_SYNC_FUNC_BIT];
					default: ;
					endcase
					if (reg_addr == `AFPC_ADDR_SOFT_RESET)
						spi_power_reg <=
						    reg_wdata[`AFPC_PWR_MSB:`AFPC_PWR_LSB];
				end
			end
			default: state_reg <= ST_START;
			endcase
			if (reg_ok & reg_rd) begin
				reg_rvalid <= 1'b1;
				reg_rdata <= rd_image;
			end
			// Differential pair routed by function select
			link_sync_n <= sync_func_reg ? 1'b1 :
			    (sync_pair_pos & ~sync_pair_neg);
			div_sync_reset <= sync_func_reg &
			    (sync_pair_pos & ~sync_pair_neg);
			lane_enable <= ~in_sleep;
			nap_active <= in_nap;
			sleep_active <= in_sleep;
			calibrating <= (state_reg != ST_RUN);
			sample_ready <= fifo_in_ready & ~sample_take;
			if (in_sleep) begin
				lane_valid <= 1'b0;
			end else if (in_nap) begin
				lane_valid <= 1'b1;
				lane_data_a <= hold_a_reg;
				lane_data_b <= hold_b_reg;
			end else if (fifo_out_valid & lane_ready) begin
				lane_valid <= 1'b1;
				lane_data_a <= fifo_out_data[2*`AFPC_W-1:`AFPC_W];
				lane_data_b <= fifo_out_data[`AFPC_W-1:0];
				hold_a_reg <= fifo_out_data[2*`AFPC_W-1:`AFPC_W];
				hold_b_reg <= fifo_out_data[`AFPC_W-1:0];
			end else begin
				lane_valid <= 1'b0;
			end
		end
	end
endmodule // afpc_top

// ==== testbench/afpc_far_model.sv ====
// Far side model: lane receiver that stalls, and calibration engine.
// Assumes the block's ref_clk and reset.
`timescale 1ns/1ns
module afpc_far_model (
	input wire ref_clk,
	input wire reset,
	input wire cal_start,
	input wire stall,
	output wire cal_done,
	output reg lane_ready
);
	integer cnt = 12;
	integer seed = 7;
	// Done drops as soon as a start is seen
	assign cal_done = cnt == 0 && !cal_start;
	always @(posedge ref_clk or posedge reset) begin
		if (reset || cal_start)
			cnt <= 12;
		else if (cnt > 0)
			cnt <= cnt - 1;
	end
	always @(posedge ref_clk)
		lane_ready <= !stall && ($random(seed) & 3) != 0;
endmodule // afpc_far_model

// ==== testbench/afpc_top_props.sv ====
// Checker for the block's port behaviour.
// Assumes binding to afpc_top, one clock domain.
`timescale 1ns/1ns
module afpc_top_props (
	input wire ref_clk,
	input wire reset,
	input wire reg_rd,
	input wire reg_rvalid,
	input wire cal_start,
	input wire calibrating,
	input wire nap_active,
	input wire sleep_active,
	input wire lane_enable,
	input wire lane_valid,
	input wire [13:0] lane_data_a,
	input wire [13:0] lane_data_b,
	input wire link_sync_n,
	input wire div_sync_reset
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	a_sleep_lanes_off: assert property (
		sleep_active |-> !lane_enable && !lane_valid) else $error("lane on");
	a_nap_lanes_on: assert property (
		$past(nap_active) && nap_active |-> lane_enable && lane_valid)
		else $error("nap lane idle");
	a_nap_data_held: assert property (
		nap_active [*3] |-> $stable(lane_data_a) && $stable(lane_data_b))
		else $error("nap data moved");
	a_cal_before_power: assert property (
		calibrating |-> !nap_active && !sleep_active) else $error("early nap");
	a_read_refused: assert property (
		reg_rd && calibrating |=> !reg_rvalid) else $error("read in cal");
	a_sync_forced: assert property (
		div_sync_reset |-> link_sync_n) else $error("sync not forced");
	a_cal_start_once: assert property (
		cal_start |=> !cal_start && calibrating) else $error("cal start");
	a_states_apart: assert property (
		!(nap_active && sleep_active)) else $error("nap and sleep");
endmodule // afpc_top_props

// ==== testbench/tb_afpc_top.sv ====
// Bench for the output format and power control block.
// Assumes the far side model supplies cal_done and lane_ready.
`timescale 1ns/1ns
`include "afpc_consts.vh"
module tb_afpc_top;
	reg ref_clk = 1'b0;
	reg reset = 1'b1;
	reg [1:0] power_state_pin = 2'h0;
	reg spi_select_low = 1'b1;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg [7:0] reg_addr = 8'h00;
	reg [7:0] reg_wdata = 8'h00;
	reg sample_valid = 1'b0;
	reg [13:0] sample_a = 14'h0000;
	reg [13:0] sample_b = 14'h0000;
	reg [3:0] flags = 4'h0;
	reg [1:0] sync_pair = 2'h2;
	reg stall = 1'b0;
	reg feed = 1'b0;
	reg [1:0] fmt = 2'h0;
	reg [31:0] r;
	reg got;
	reg [7:0] d;
	reg [55:0] exp_q[$];
	integer num_errors = 0, checked = 0, cycles = 0, seed = 32'h6445, f;
	wire [7:0] reg_rdata;
	wire [13:0] lane_data_a, lane_data_b;
	wire reg_rvalid, cal_done, cal_start, link_sync_n, div_sync_reset;
	wire lane_enable, lane_valid, lane_ready, sample_ready;
	wire nap_active, sleep_active, calibrating;
	wire [27:0] lanes = {lane_data_a, lane_data_b};
	always #20 ref_clk = ~ref_clk;
	afpc_top dut (.ref_clk(ref_clk), .reset(reset),
		.power_state_pin(power_state_pin), .spi_select_low(spi_select_low),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.cal_done(cal_done), .cal_start(cal_start),
		.sample_valid(sample_valid), .sample_a(sample_a), .sample_b(sample_b),
		.over_a(flags[0]), .over_b(flags[1]), .under_a(flags[2]),
		.under_b(flags[3]), .sync_pair_pos(sync_pair[1]),
		.sync_pair_neg(sync_pair[0]), .link_sync_n(link_sync_n),
		.div_sync_reset(div_sync_reset), .lane_enable(lane_enable),
		.lane_valid(lane_valid), .lane_data_a(lane_data_a),
		.lane_data_b(lane_data_b), .lane_ready(lane_ready),
		.sample_ready(sample_ready), .nap_active(nap_active),
		.sleep_active(sleep_active), .calibrating(calibrating));
	afpc_far_model far (.ref_clk(ref_clk), .reset(reset),
		.cal_start(cal_start), .stall(stall), .cal_done(cal_done),
		.lane_ready(lane_ready));
	function [13:0] clampb(input [13:0] s, input ov, input un);
		clampb = ov ? 14'h3fff : un ? 14'h0000 : s;
	endfunction
	function [13:0] ungray(input [13:0] g);
		integer k;
		begin
			ungray[13] = g[13];
			for (k = 12; k >= 0; k = k - 1)
				ungray[k] = g[k] ^ ungray[k + 1];
		end
	endfunction
	function [13:0] enc(input [13:0] s, input ov, input un);
		reg [13:0] b;
		begin
			b = clampb(s, ov, un);
			if (fmt == `AFPC_FMT_GRAY)
				enc = b ^ (b >> 1);
			else if (fmt == `AFPC_FMT_OFFSET)
				enc = b;
			else
				enc = b ^ 14'h2000;
		end
	endfunction
	task check(input logic ok, input string msg);
		begin
			checked = checked + 1;
			if (ok !== 1'b1) begin
				num_errors = num_errors + 1;
				$display("wrong value at %0t: %s", $time, msg);
			end
		end
	endtask
	task close_out;
		begin
			$display("checks %0d errors %0d", checked, num_errors);
			if (num_errors == 0 && checked > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	task access(input wr, input [7:0] a, input [7:0] wd);
		integer i;
		begin
			@(posedge ref_clk);
			spi_select_low <= 1'b0;
			reg_wr <= wr;
			reg_rd <= !wr;
			reg_addr <= a;
			reg_wdata <= wd;
			@(posedge ref_clk);
			reg_wr <= 1'b0;
			reg_rd <= 1'b0;
			spi_select_low <= 1'b1;
			got = 1'b0;
			for (i = 0; i < 3; i = i + 1) begin
				@(posedge ref_clk);
				if (reg_rvalid === 1'b1 && !wr) begin
					got = 1'b1;
					d = reg_rdata;
				end
			end
		end
	endtask
	task wait_cal;
		integer i;
		begin
			for (i = 0; i < 100 && calibrating !== 1'b0; i = i + 1)
				@(posedge ref_clk);
			check(calibrating === 1'b0, "cal end");
		end
	endtask
	task pin_step(input [1:0] p);
		begin
			power_state_pin <= p;
			repeat (6) @(posedge ref_clk);
		end
	endtask
	always @(posedge ref_clk) begin
		cycles = cycles + 1;
		if (cycles == 30000) begin
			num_errors = num_errors + 1;
			close_out;
		end
	end
	always @(posedge ref_clk) begin
		if (sample_valid && sample_ready)
			exp_q.push_back({enc(sample_a, flags[0], flags[2]),
				enc(sample_b, flags[1], flags[3]),
				clampb(sample_a, flags[0], flags[2]),
				clampb(sample_b, flags[1], flags[3])});
		if (lane_valid && !nap_active) begin
			check(lanes === exp_q[0][55:28], "lane");
			if (fmt == `AFPC_FMT_GRAY)
				check(ungray(lane_data_a) === exp_q[0][27:14] &&
				    ungray(lane_data_b) === exp_q[0][13:0], "gray back");
			void'(exp_q.pop_front());
		end
		r = $random(seed);
		sample_a <= r[1:0] == 0 ? 14'h2000 : r[15:2];
		sample_b <= r[29:16];
		flags <= r[31:29] == 0 ? 4'h1 : r[31:29] == 1 ? 4'h8 : 4'h0;
		sample_valid <= feed && !sample_valid && sample_ready && r[16];
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		wait_cal;
		access(0, `AFPC_ADDR_FORMAT, 8'h00);
		check(got && d[1:0] === `AFPC_FMT_TWOS, "fmt default");
		access(0, 8'h55, 8'h00);
		check(got !== 1'b1 || d === 8'h00, "unmapped");
		for (f = 2; f >= 0; f = f - 1) begin
			fmt <= f[1:0];
			access(1, `AFPC_ADDR_FORMAT, {6'h00, f[1:0]});
			feed <= 1'b1;
			stall <= f == 1;
			repeat (300) @(posedge ref_clk);
			check(f != 1 || sample_ready === 1'b0, "full");
			feed <= 1'b0;
			stall <= 1'b0;
			repeat (80) @(posedge ref_clk);
			check(exp_q.size() == 0 && sample_ready === 1'b1, "drain");
		end
		pin_step(`AFPC_PIN_NAP);
		check(nap_active === 1'b1 && lane_enable === 1'b1, "nap");
		access(1, `AFPC_ADDR_SOFT_RESET, 8'h10);
		check(nap_active === 1'b0, "override normal");
		access(1, `AFPC_ADDR_SOFT_RESET, 8'h30);
		check(sleep_active === 1'b1, "override sleep");
		access(1, `AFPC_ADDR_SOFT_RESET, 8'h00);
		pin_step(`AFPC_PIN_SLEEP);
		check(sleep_active === 1'b1 && lane_enable === 1'b0, "sleep");
		pin_step(`AFPC_PIN_NORMAL);
		sync_pair <= 2'h1;
		repeat (3) @(posedge ref_clk);
		check(link_sync_n === 1'b0 && div_sync_reset === 1'b0, "sync");
		access(1, `AFPC_ADDR_SYNC_FUNC, 8'h01);
		check(link_sync_n === 1'b1, "sync forced");
		sync_pair <= 2'h2;
		repeat (3) @(posedge ref_clk);
		check(div_sync_reset === 1'b1, "divider reset");
		access(1, `AFPC_ADDR_SOFT_RESET, 8'h01);
		check(calibrating === 1'b1, "recal");
		access(0, `AFPC_ADDR_FORMAT, 8'h00);
		check(got === 1'b0, "cal refuses");
		wait_cal;
		access(0, `AFPC_ADDR_SOFT_RESET, 8'h00);
		check(got && d[0] === 1'b0, "self clear");
		power_state_pin <= `AFPC_PIN_NAP;
		reset <= 1'b1;
		repeat (4) @(posedge ref_clk);
		reset <= 1'b0;
		wait_cal;
		pin_step(`AFPC_PIN_NAP);
		check(nap_active === 1'b1, "nap after cal");
		access(0, `AFPC_ADDR_FORMAT, 8'h00);
		check(got === 1'b0, "spi off");
		pin_step(`AFPC_PIN_NORMAL);
		access(0, `AFPC_ADDR_FORMAT, 8'h00);
		check(got && d[1:0] === `AFPC_FMT_TWOS, "spi on");
		close_out;
	end
endmodule // tb_afpc_top
bind afpc_top afpc_top_props chk (.ref_clk(ref_clk), .reset(reset),
	.reg_rd(reg_rd), .reg_rvalid(reg_rvalid), .cal_start(cal_start),
	.calibrating(calibrating), .nap_active(nap_active),
	.sleep_active(sleep_active), .lane_enable(lane_enable),
	.lane_valid(lane_valid), .lane_data_a(lane_data_a),
	.lane_data_b(lane_data_b), .link_sync_n(link_sync_n),
	.div_sync_reset(div_sync_reset));
